/* verilog/ext_irq_defines.vh */
// Offsets, field positions, sense encodings and vectors for the pin interrupt unit
`ifndef EXT_IRQ_DEFINES_VH
`define EXT_IRQ_DEFINES_VH

// Register word addresses (word index, as driven on address)
`define REG_SENSE_CTRL    4'h0
`define REG_REQ_ENABLE    4'h1
`define REG_REQ_FLAGS     4'h2
`define REG_GROUP_ENABLE  4'h3
`define REG_MASK_GROUP_0  4'h4
`define REG_MASK_GROUP_1  4'h5
`define REG_MASK_GROUP_2  4'h6
`define REG_MASK_GROUP_3  4'h7
`define REG_GLOBAL_CTRL   4'h8
`define REG_IRQ_STATUS    4'h9
`define REG_IRQ_CLEAR     4'hA
`define REG_IRQ_ENABLE    4'hB
`define REG_VECTOR        4'hC

// Sense control fields and encodings
`define SENSE0_LSB        0
`define SENSE1_LSB        2
`define SENSE_LOW         2'h0
`define SENSE_ANY         2'h1
`define SENSE_FALL        2'h2
`define SENSE_RISE        2'h3

// Vector words
`define VEC_RESET         7'h00
`define VEC_REQ0          7'h01
`define VEC_REQ1          7'h02
`define VEC_GROUP0        7'h03
`define VEC_WATCHDOG      7'h07
`define VEC_TWO_WIRE      7'h13
`define VEC_NONE          7'h7F

`define NUM_PC_PINS       28
`define NUM_SOURCES       8

`endif

/* verilog/pin_change_group.v */
// One pin-change group: captures any unmasked toggle into a pending flag
`timescale 1ns/100ps
module pin_change_group #(
	parameter WIDTH = 8
) (
	input  wire             ref_clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] pins,
	input  wire [WIDTH-1:0] mask,
	input  wire             clear,
	output reg              pending_q
);
	reg  [WIDTH-1:0] sync1_q;
	reg  [WIDTH-1:0] sync2_q;
	reg  [WIDTH-1:0] prev_q;
	wire [WIDTH-1:0] changed;

	// Per-pin toggle detect; pins read as seen, even when driven by us
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
			assign changed[i] = mask[i] & (sync2_q[i] ^ prev_q[i]);
		end
	endgenerate

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= {WIDTH{1'b0}};
			sync2_q <= {WIDTH{1'b0}};
			prev_q  <= {WIDTH{1'b0}};
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// Set wins over clear so a change in the clear cycle is kept
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pending_q <= 1'b0;
		else if (|changed)
			pending_q <= 1'b1;
		else if (clear)
			pending_q <= 1'b0;
	end
endmodule

/* verilog/ext_pin_irq.v */
// External request pins, pin-change groups, vectoring and register slave
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "ext_irq_defines.vh"
module ext_pin_irq (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire [3:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	input  wire        ext_request_pin_0,
	input  wire        ext_request_pin_1,
	input  wire [27:0] pin_change_inputs,
	input  wire        io_clock_run,
	input  wire        vector_ack,
	input  wire [6:0]  ack_vector,
	output reg  [6:0]  vector_q,
	output reg         vector_valid_q,
	output reg         irq_q
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	reg  [3:0]  ext_sense_control_reg_q;
	reg  [1:0]  ext_request_enable_reg_q;
	reg  [3:0]  group_enable_q;
	reg  [7:0]  pin_change_mask_group_0_q;
	reg  [7:0]  pin_change_mask_group_1_q;
	reg  [7:0]  pin_change_mask_group_2_q;
	reg  [3:0]  pin_change_mask_group_3_q;
	reg         global_enable_q;
	reg  [1:0]  pending_flag_q;
	reg  [5:0]  irq_status_q;
	reg  [5:0]  irq_enable_q;
	reg         access_done_q;

	wire        bus_req;
	wire        wr_hit;
	wire [1:0]  flag_wr_clear;
	wire [5:0]  status_wr_clear;
	wire [3:0]  group_pending;
	wire [3:0]  group_clear;

	assign bus_req = (read | write) & ~access_done_q;
	assign wr_hit  = write & ~access_done_q;
	assign flag_wr_clear = (wr_hit && address == `REG_REQ_FLAGS) ?
		writedata[1:0] : 2'h0;
	assign status_wr_clear = (wr_hit && address == `REG_IRQ_CLEAR) ?
		writedata[5:0] : 6'h00;

	////////////////////////////////////////////////////////////////////////
	// Request pin synchronisers and edge detect
	reg  [1:0]  req_sync1_q;
	reg  [1:0]  req_sync2_q;
	reg  [1:0]  req_prev_q;
	wire [1:0]  req_pin;
	wire [1:0]  req_trig;
	wire [1:0]  req_level_mode;

	assign req_pin = {ext_request_pin_1, ext_request_pin_0};

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_sync1_q <= 2'h3;
			req_sync2_q <= 2'h3;
		end else begin
			req_sync1_q <= req_pin;
			req_sync2_q <= req_sync1_q;
		end
	end

	// Previous copy reads only the second stage, never the first
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			req_prev_q <= 2'h3;
		else
			req_prev_q <= req_sync2_q;
	end

	// Sense decode; edges seen only while the clock domain runs
	genvar k;
	generate
		for (k = 0; k < 2; k = k + 1) begin : g_req
			wire [1:0] sense;
			wire       rise;
			wire       fall;
			assign sense = ext_sense_control_reg_q[2*k+1:2*k];
			assign rise  = req_sync2_q[k] & ~req_prev_q[k];
			assign fall  = ~req_sync2_q[k] & req_prev_q[k];
			assign req_level_mode[k] = (sense == `SENSE_LOW);
			// Two-stage sample catches any pulse wider than a clock
			assign req_trig[k] = io_clock_run & (
				(sense == `SENSE_ANY  & (rise | fall)) |
				(sense == `SENSE_FALL & fall) |
				(sense == `SENSE_RISE & rise));
		end
	endgenerate

	// Pending flags: set wins over clear, held low in level mode
	integer j;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pending_flag_q <= 2'h0;
		else
			for (j = 0; j < 2; j = j + 1) begin
				if (req_level_mode[j])
					pending_flag_q[j] <= 1'b0;
				else if (req_trig[j])
					pending_flag_q[j] <= 1'b1;
				else if (flag_wr_clear[j] ||
					(vector_ack && ack_vector == `VEC_REQ0 + j))
					pending_flag_q[j] <= 1'b0;
			end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin-change groups
	wire [27:0] group_mask;

	// Sampled copies also serve the sleep path: toggles latch asynchronously
	// in silicon; here they are caught from the first running edge
	assign group_mask = {pin_change_mask_group_3_q, pin_change_mask_group_2_q,
		pin_change_mask_group_1_q, pin_change_mask_group_0_q};

	generate
		for (k = 0; k < 4; k = k + 1) begin : g_grp
			localparam LSB = 8 * k;
			localparam W   = (k == 3) ? 4 : 8;
			assign group_clear[k] = vector_ack &&
				ack_vector == `VEC_GROUP0 + k;
			pin_change_group #(
				.WIDTH (W)
			) u_group (
				.ref_clk   (ref_clk),
				.rst_n     (rst_n),
				.pins      (pin_change_inputs[LSB+W-1:LSB]),
				.mask      (group_mask[LSB+W-1:LSB]),
				.clear     (group_clear[k]),
				.pending_q (group_pending[k])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Vectoring: lowest vector word wins
	wire [5:0] active;
	reg  [6:0] vector_d;

	// Level mode requests for as long as the pin reads low
	assign active[0] = ext_request_enable_reg_q[0] &
		(req_level_mode[0] ? ~req_sync2_q[0] : pending_flag_q[0]);
	assign active[1] = ext_request_enable_reg_q[1] &
		(req_level_mode[1] ? ~req_sync2_q[1] : pending_flag_q[1]);
	assign active[5:2] = group_enable_q & group_pending;

	always @* begin
		vector_d = `VEC_NONE;
		if (!global_enable_q)
			vector_d = `VEC_NONE;
		else if (active[0])
			vector_d = `VEC_REQ0;
		else if (active[1])
			vector_d = `VEC_REQ1;
		else if (active[2])
			vector_d = `VEC_GROUP0;
		else if (active[3])
			vector_d = `VEC_GROUP0 + 7'h01;
		else if (active[4])
			vector_d = `VEC_GROUP0 + 7'h02;
		else if (active[5])
			vector_d = `VEC_GROUP0 + 7'h03;
	end

	// Other sources own words 0x007..0x013 and never issue here
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			vector_q <= `VEC_RESET;
		else
			vector_q <= vector_d;
	end

	// Valid travels with the word so the CPU never sees a stale pair
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			vector_valid_q <= 1'b0;
		else
			vector_valid_q <= (vector_d != `VEC_NONE);
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky status and interrupt line
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			irq_status_q <= 6'h00;
		else
			irq_status_q <= (irq_status_q & ~status_wr_clear) | active;
	end

	// Line lags status by one clock; kept registered for a clean output
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_status_q & irq_enable_q);
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, answer on the second edge
	// A master must drop its request at the answer edge; a request held
	// longer is taken again two cycles later, which costs one cycle per
	// access but keeps the slave free of any state beyond one flag
	reg  [31:0] read_mux_d;

	// Unmapped and write-only words read as zero
	always @* begin
		read_mux_d = 32'h0;
		case (address)
		`REG_SENSE_CTRL:   read_mux_d = {28'h0, ext_sense_control_reg_q};
		`REG_REQ_ENABLE:   read_mux_d = {30'h0, ext_request_enable_reg_q};
		`REG_REQ_FLAGS:    read_mux_d = {30'h0, pending_flag_q};
		`REG_GROUP_ENABLE: read_mux_d = {28'h0, group_enable_q};
		`REG_MASK_GROUP_0: read_mux_d = {24'h0, pin_change_mask_group_0_q};
		`REG_MASK_GROUP_1: read_mux_d = {24'h0, pin_change_mask_group_1_q};
		`REG_MASK_GROUP_2: read_mux_d = {24'h0, pin_change_mask_group_2_q};
		`REG_MASK_GROUP_3: read_mux_d = {28'h0, pin_change_mask_group_3_q};
		`REG_GLOBAL_CTRL:  read_mux_d = {31'h0, global_enable_q};
		`REG_IRQ_STATUS:   read_mux_d = {26'h0, irq_status_q};
		`REG_IRQ_ENABLE:   read_mux_d = {26'h0, irq_enable_q};
		`REG_VECTOR:       read_mux_d = {24'h0, vector_valid_q, vector_q};
		default:           read_mux_d = 32'h0;
		endcase
	end

	// Done flag blocks a second take of a request still held high
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			access_done_q <= 1'b0;
		else
			access_done_q <= bus_req;
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= ~bus_req;
	end

	// Loaded at the take edge, held until the next read
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			readdata <= 32'h0;
		else if (bus_req && read)
			readdata <= read_mux_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes, one strobe and one process per register
	wire        wr_sense;
	wire        wr_req_enable;
	wire        wr_group_enable;
	wire        wr_mask_0;
	wire        wr_mask_1;
	wire        wr_mask_2;
	wire        wr_mask_3;
	wire        wr_global;
	wire        wr_irq_enable;

	assign wr_sense        = wr_hit && (address == `REG_SENSE_CTRL);
	assign wr_req_enable   = wr_hit && (address == `REG_REQ_ENABLE);
	assign wr_group_enable = wr_hit && (address == `REG_GROUP_ENABLE);
	assign wr_mask_0       = wr_hit && (address == `REG_MASK_GROUP_0);
	assign wr_mask_1       = wr_hit && (address == `REG_MASK_GROUP_1);
	assign wr_mask_2       = wr_hit && (address == `REG_MASK_GROUP_2);
	assign wr_mask_3       = wr_hit && (address == `REG_MASK_GROUP_3);
	assign wr_global       = wr_hit && (address == `REG_GLOBAL_CTRL);
	assign wr_irq_enable   = wr_hit && (address == `REG_IRQ_ENABLE);

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ext_sense_control_reg_q <= 4'h0;
		else if (wr_sense)
			ext_sense_control_reg_q <= writedata[3:0];
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ext_request_enable_reg_q <= 2'h0;
		else if (wr_req_enable)
			ext_request_enable_reg_q <= writedata[1:0];
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			group_enable_q <= 4'h0;
		else if (wr_group_enable)
			group_enable_q <= writedata[3:0];
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pin_change_mask_group_0_q <= 8'h00;
		else if (wr_mask_0)
			pin_change_mask_group_0_q <= writedata[7:0];
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pin_change_mask_group_1_q <= 8'h00;
		else if (wr_mask_1)
			pin_change_mask_group_1_q <= writedata[7:0];
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pin_change_mask_group_2_q <= 8'h00;
		else if (wr_mask_2)
			pin_change_mask_group_2_q <= writedata[7:0];
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pin_change_mask_group_3_q <= 4'h0;
		else if (wr_mask_3)
			pin_change_mask_group_3_q <= writedata[3:0];
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			global_enable_q <= 1'b0;
		else if (wr_global)
			global_enable_q <= writedata[0];
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			irq_enable_q <= 6'h00;
		else if (wr_irq_enable)
			irq_enable_q <= writedata[5:0];
	end
endmodule

/* sim/ext_pin_irq_sva.sv */
// Checker for the bus handshake, vector output and request pin sensing
`timescale 1ns/100ps
module ext_pin_irq_chk (
	input wire        ref_clk,
	input wire        rst_n,
	input wire [3:0]  address,
	input wire        read,
	input wire        write,
	input wire [31:0] writedata,
	input wire [31:0] readdata,
	input wire        waitrequest,
	input wire        ext_request_pin_0,
	input wire        io_clock_run,
	input wire [6:0]  vector_q,
	input wire        vector_valid_q
);
	reg  [1:0] sense_q;
	reg        en_q;
	reg        glb_q;
	wire       done = write && !waitrequest;
	wire       lvl = sense_q == 2'h0 && en_q && glb_q;
	wire       fall = sense_q == 2'h2 && en_q && glb_q && io_clock_run;
	////////////////////////////////////////
	// Shadow of the request 0 setup, so the checker needs no internals
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_q <= 2'h0;
			en_q <= 1'b0;
			glb_q <= 1'b0;
		end else if (done) begin
			if (address == 4'h0)
				sense_q <= writedata[1:0];
			if (address == 4'h1)
				en_q <= writedata[0];
			if (address == 4'h8)
				glb_q <= writedata[0];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_fall;
		fall && $fell(ext_request_pin_0) ##1 fall && !ext_request_pin_0;
	endsequence
	sequence s_low;
		(lvl && !ext_request_pin_0) [*6];
	endsequence
	property p_wait_one; !waitrequest |=> waitrequest; endproperty
	property p_answer;
		(read || write) && waitrequest |-> ##[1:2] !waitrequest;
	endproperty
	property p_rd_hold; !$stable(readdata) |-> read && !waitrequest; endproperty
	property p_unmapped;
		read && !waitrequest && address >= 4'hD |-> readdata == 32'h0;
	endproperty
	property p_stat_width;
		read && !waitrequest && address == 4'h9 |-> readdata[31:6] == 26'h0;
	endproperty
	property p_none; $past(rst_n) && !vector_valid_q |-> vector_q == 7'h7F;
	endproperty
	property p_range; vector_valid_q |-> vector_q >= 7'h01 && vector_q <= 7'h06;
	endproperty
	property p_level; s_low |-> vector_valid_q && vector_q == 7'h01; endproperty
	property p_fall;
		s_fall |-> ##[3:4] vector_valid_q && vector_q == 7'h01;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer too long");
	a_answer: assert property (p_answer) else $error("no bus answer");
	a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
	a_unmapped: assert property (p_unmapped) else $error("unmapped nonzero");
	a_stat_width: assert property (p_stat_width) else $error("status width");
	a_none: assert property (p_none) else $error("idle vector");
	a_range: assert property (p_range) else $error("bad vector");
	a_level: assert property (p_level) else $error("level lost");
	a_fall: assert property (p_fall) else $error("edge missed");
endmodule

/* sim/pin_source.sv */
// Pin source standing in for external drivers or the part's own outputs
`timescale 1ns/100ps
module pin_source (
	input  wire        ref_clk,
	output reg         ext_request_pin_0,
	output reg         ext_request_pin_1,
	output reg  [27:0] pin_change_inputs
);
	////////////////////////////////////////
	initial begin
		ext_request_pin_0 = 1'b1;
		ext_request_pin_1 = 1'b0;
		pin_change_inputs = 28'h0;
	end
	// Levels held three clocks, past the one clock minimum pulse
	task set(input p0, input p1, input [27:0] pc);
		begin
			@(posedge ref_clk);
			ext_request_pin_0 <= p0;
			ext_request_pin_1 <= p1;
			pin_change_inputs <= pc;
			repeat (3) @(posedge ref_clk);
		end
	endtask
endmodule

/* sim/test_external_pin_interrupt_unit.sv */
// Self-checking bench for the pin interrupt unit
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
	fails++; $display("MISMATCH %s exp %0h seen %0h", n, e, a); end end
module test_external_pin_interrupt_unit;
	reg         ref_clk;
	reg         rst_n;
	reg  [3:0]  address;
	reg         read;
	reg         write;
	reg  [31:0] writedata;
	wire [31:0] readdata;
	wire        waitrequest;
	wire        p0;
	wire        p1;
	wire [27:0] pcin;
	reg         io_clock_run;
	reg         vector_ack;
	reg  [6:0]  ack_vector;
	wire [6:0]  vector_q;
	wire        vector_valid_q;
	wire        irq_q;
	integer     fails = 0;
	integer     checks_done = 0;
	integer     g;
	reg  [31:0] d;
	reg  [27:0] pcv = 28'h0;
	ext_pin_irq ext_pin_irq_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.ext_request_pin_0(p0), .ext_request_pin_1(p1),
		.pin_change_inputs(pcin), .io_clock_run(io_clock_run),
		.vector_ack(vector_ack), .ack_vector(ack_vector),
		.vector_q(vector_q), .vector_valid_q(vector_valid_q), .irq_q(irq_q));
	pin_source pin_source_inst (.ref_clk(ref_clk), .ext_request_pin_0(p0),
		.ext_request_pin_1(p1), .pin_change_inputs(pcin));
	////////////////////////////////////////
	task bus(input w, input [3:0] a, input [31:0] v);
		begin
			@(posedge ref_clk);
			address <= a;
			writedata <= v;
			write <= w;
			read <= !w;
			@(posedge ref_clk);
			while (waitrequest !== 1'b0) @(posedge ref_clk);
			d = readdata;
			write <= 1'b0;
			read <= 1'b0;
		end
	endtask
	task chkrd(input [3:0] a, input [31:0] e, input string n);
		begin
			bus(1'b0, a, 32'h0);
			`CHK(n, e, d)
		end
	endtask
	// Vector, valid and irq together, after the longest path has settled
	task look(input [8:0] e);
		begin
			repeat (8) @(posedge ref_clk);
			`CHK("vector", e, {vector_valid_q, vector_q, irq_q})
		end
	endtask
	task ack(input [6:0] v);
		begin
			@(posedge ref_clk);
			vector_ack <= 1'b1;
			ack_vector <= v;
			@(posedge ref_clk);
			vector_ack <= 1'b0;
		end
	endtask
	task t_reset;
		begin
			for (g = 0; g < 9; g++)
				chkrd(g[3:0], 32'h0, "reg");
			chkrd(4'hC, 32'h7F, "vec reg");
			chkrd(4'hD, 32'h0, "unmapped");
			$display("test reset done");
		end
	endtask
	task t_fall;
		begin
			bus(1'b1, 4'h0, 32'h2);
			bus(1'b1, 4'h1, 32'h1);
			bus(1'b1, 4'h8, 32'h1);
			bus(1'b1, 4'hB, 32'h1);
			pin_source_inst.set(1'b0, 1'b0, pcv);
			look(9'h103);
			chkrd(4'h2, 32'h1, "flags");
			ack(7'h01);
			look(9'h0FF);
			bus(1'b1, 4'hA, 32'h1);
			look(9'h0FE);
			pin_source_inst.set(1'b1, 1'b0, pcv);
			look(9'h0FE);
			$display("test fall done");
		end
	endtask
	task t_rise;
		begin
			bus(1'b1, 4'h1, 32'h2);
			bus(1'b1, 4'h0, 32'hC);
			bus(1'b1, 4'hB, 32'h0);
			@(posedge ref_clk) io_clock_run <= 1'b0;
			pin_source_inst.set(1'b1, 1'b1, pcv);
			look(9'h0FE);
			pin_source_inst.set(1'b1, 1'b0, pcv);
			@(posedge ref_clk) io_clock_run <= 1'b1;
			pin_source_inst.set(1'b1, 1'b1, pcv);
			look(9'h104);
			chkrd(4'h9, 32'h2, "status");
			bus(1'b1, 4'h2, 32'h2);
			look(9'h0FE);
			bus(1'b1, 4'h0, 32'h4);
			pin_source_inst.set(1'b1, 1'b0, pcv);
			look(9'h104);
			bus(1'b1, 4'h2, 32'h2);
			bus(1'b1, 4'hA, 32'h3F);
			$display("test rise done");
		end
	endtask
	task t_level;
		begin
			bus(1'b1, 4'h0, 32'h0);
			bus(1'b1, 4'h1, 32'h1);
			bus(1'b1, 4'hB, 32'h1);
			pin_source_inst.set(1'b0, 1'b0, pcv);
			look(9'h103);
			chkrd(4'h2, 32'h0, "flags");
			ack(7'h01);
			look(9'h103);
			pin_source_inst.set(1'b1, 1'b0, pcv);
			bus(1'b1, 4'hA, 32'h3F);
			look(9'h0FE);
			bus(1'b1, 4'h8, 32'h0);
			pin_source_inst.set(1'b0, 1'b0, pcv);
			look(9'h0FF);
			pin_source_inst.set(1'b1, 1'b0, pcv);
			bus(1'b1, 4'h8, 32'h1);
			bus(1'b1, 4'h1, 32'h0);
			bus(1'b1, 4'hB, 32'h3C);
			$display("test level done");
		end
	endtask
	task t_groups;
		reg [6:0] v;
		begin
			bus(1'b1, 4'h3, 32'hF);
			for (g = 0; g < 4; g++) begin
				v = 7'h03 + g[6:0];
				bus(1'b1, 4'h4 + g[3:0], 32'h2);
				bus(1'b1, 4'hA, 32'h3F);
				pcv[8 * g] = !pcv[8 * g];
				pin_source_inst.set(1'b1, 1'b0, pcv);
				look(9'h0FE);
				pcv[8 * g + 1] = !pcv[8 * g + 1];
				pin_source_inst.set(1'b1, 1'b0, pcv);
				look({1'b1, v, 1'b1});
				ack(v);
			end
			$display("test groups done");
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", checks_done, fails);
			if (fails == 0 && checks_done > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = !ref_clk;
	end
	// Tests need about 400 clocks; fifty times that means a hang
	initial begin
		#200000;
		fails++;
		end_sim;
	end
	initial begin
		rst_n = 1'b0;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		io_clock_run = 1'b1;
		vector_ack = 1'b0;
		ack_vector = 7'h00;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset;
		t_fall;
		t_rise;
		t_level;
		t_groups;
		end_sim;
	end
endmodule
bind ext_pin_irq ext_pin_irq_chk ext_pin_irq_chk_inst (.ref_clk(ref_clk),
	.rst_n(rst_n), .address(address), .read(read), .write(write),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.ext_request_pin_0(ext_request_pin_0), .io_clock_run(io_clock_run),
	.vector_q(vector_q), .vector_valid_q(vector_valid_q));
